// ==== logic/lcd_command_decoder_regs.sv ====
`timescale 1ns/1ps
`include "lcd_cmd_params.svh"

// Notes on behaviour
// - Select line picks command or data, rw picks direction.
// - Data bytes access memory at page and column.
// - Status reads busy, mirror, display, reset flags.
// - Two nibble commands load the column pointer.
// - Power control low bits load; reset off.
// - Scroll line loads six bits; icons unaffected.
// - Page pointer loads four bits, page eight icons.
// - Resistor ratio loads power bits five to three.
// - Two-byte contrast command loads six-bit volume.
// - All pixels on forces segments, memory kept.
// - Invert shows complement of memory, memory kept.
// - Display enable wakes power then drivers.
// - Segment mirror reverses column order immediately.
// - Common mirror reverses row order immediately.
// - Software reset restores registers, keeps memory.
// - Listed no-op bytes and unknown patterns ignored.
// - Cursor hold saves column, restore on exit.
// - Advanced control byte sets slope and wraps.
// - Power save is display off plus all on; sleep_mode follows display off alone.
// - Hardware reset loads documented default values.
// - Bias ratio command is 1010001x.
// - Column increments on writes, reads outside hold.
module lcd_command_decoder_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe_pin,
  input wire logic command_data_select,
  input wire logic read_write_select,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  output logic [5:0] scroll_line,
  output logic [5:0] contrast_volume,
  output logic [5:0] power_control,
  output logic bias_ratio_select,
  output logic pixel_invert,
  output logic all_pixels_on,
  output logic display_on_flag,
  output logic sleep_mode,
  output logic drivers_enable,
  output logic seg_mirror,
  output logic com_mirror,
  output logic bias_temp_slope,
  output logic cursor_hold_mode,
  output logic busy_flag,
  output logic reset_in_progress
);
  // Pins come from the host clock domain: two flops each before use.
  logic stb_s1_r, stb_s2_r;
  logic stb_prev_r;
  logic [9:0] dat_s1_r, dat_s2_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stb_s1_r <= 1'b0;
      stb_s2_r <= 1'b0;
      stb_prev_r <= 1'b0;
      dat_s1_r <= 10'h000;
      dat_s2_r <= 10'h000;
    end
    else
    begin
      stb_s1_r <= strobe_pin;
      stb_s2_r <= stb_s1_r;
      stb_prev_r <= stb_s2_r;
      dat_s1_r <= {command_data_select, read_write_select, bus_in};
      dat_s2_r <= dat_s1_r;
    end
  end

  logic access;
  logic is_data, is_read;
  logic [7:0] byte_in;
  // One access per rising edge of the synchronised strobe.
  assign access = stb_s2_r && !stb_prev_r;
  assign is_data = dat_s2_r[9];
  assign is_read = dat_s2_r[8];
  assign byte_in = dat_s2_r[7:0];

  mem_port_if mp ();
  display_memory #(.PAGES(9), .COLS(132)) u_mem (.clk(clk), .mp(mp));

  lcd_cmd_pkg::ctrl_s ctrl_r, ctrl_nxt;
  lcd_cmd_pkg::arg_e arg_r, arg_nxt;
  logic [7:0] col_r, col_nxt, ret_r, ret_nxt;
  logic [3:0] page_r, page_nxt;
  logic hold_r, hold_nxt;
  logic [3:0] rcnt_r, rcnt_nxt;
  logic [7:0] out_r, out_nxt;
  logic oe_r, oe_nxt;

  // Column advance with optional wrap; wrap is suspended in hold mode.
  function automatic logic [7:0] next_col(input logic [7:0] c, input logic wrap);
    logic [7:0] r;
    r = c;
    if (c < `COL_LAST)
    begin
      r = c + 8'h01;
    end
    else if (wrap)
    begin
      r = 8'h00;
    end
    return r;
  endfunction

  // Page advance used when the column wraps.
  function automatic logic [3:0] next_page(input logic [3:0] p, input logic wrap);
    logic [3:0] r;
    r = p;
    if (p < `PAGE_LAST)
    begin
      r = p + 4'h1;
    end
    else if (wrap)
    begin
      r = 4'h0;
    end
    return r;
  endfunction

  // Defaults shared by hardware and software reset; memory is never touched.
  function automatic lcd_cmd_pkg::ctrl_s ctrl_default();
    lcd_cmd_pkg::ctrl_s d;
    d.scroll_line = `RST_SCROLL;
    d.contrast_volume = `RST_CONTRAST;
    d.power_control = `RST_POWER;
    d.bias_ratio_select = 1'b0;
    d.display_control_flags = 3'h0;
    d.panel_mirror_control = 2'h0;
    d.advanced_control_0 = `RST_ADV0;
    return d;
  endfunction

  logic col_wrap, page_wrap, at_col_end;
  assign col_wrap = ctrl_r.advanced_control_0[`ADV0_COL_WRAP];
  assign page_wrap = ctrl_r.advanced_control_0[`ADV0_PAGE_WRAP];
  assign at_col_end = (col_r == `COL_LAST);

  // Memory port follows the pointers directly.
  assign mp.wr_en = access && is_data && !is_read && (rcnt_r == 4'h0);
  assign mp.page = page_r;
  assign mp.column = col_r;
  assign mp.wr_data = byte_in;

  // Command decode and pointer updates. Commands during reset are dropped,
  // since the host is expected to wait for busy to clear.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    arg_nxt = arg_r;
    col_nxt = col_r;
    page_nxt = page_r;
    ret_nxt = ret_r;
    hold_nxt = hold_r;
    rcnt_nxt = (rcnt_r != 4'h0) ? rcnt_r - 4'h1 : 4'h0;
    out_nxt = out_r;
    oe_nxt = oe_r;
    if (access && !(!is_data && is_read))
    begin
      oe_nxt = 1'b0;
    end
    if (access && rcnt_r == 4'h0)
    begin
      if (is_data)
      begin
        if (is_read)
        begin
          out_nxt = mp.rd_data;
          oe_nxt = 1'b1;
          if (!hold_r)
          begin
            col_nxt = next_col(col_r, col_wrap);
            if (at_col_end && col_wrap)
            begin
              page_nxt = next_page(page_r, page_wrap);
            end
          end
        end
        else if (hold_r)
        begin
          col_nxt = next_col(col_r, 1'b0);
        end
        else
        begin
          col_nxt = next_col(col_r, col_wrap);
          if (at_col_end && col_wrap)
          begin
            page_nxt = next_page(page_r, page_wrap);
          end
        end
      end
      else if (is_read)
      begin
        out_nxt = 8'h00;
        out_nxt[`ST_BUSY] = 1'b0;
        out_nxt[`ST_MIRROR] = ctrl_r.panel_mirror_control[0];
        out_nxt[`ST_DISP] = ctrl_r.display_control_flags[2];
        out_nxt[`ST_RESET] = 1'b0;
        oe_nxt = 1'b1;
      end
      else if (arg_r == lcd_cmd_pkg::ARG_CONTRAST)
      begin
        ctrl_nxt.contrast_volume = byte_in[5:0];
        arg_nxt = lcd_cmd_pkg::ARG_NONE;
      end
      else if (arg_r == lcd_cmd_pkg::ARG_ADV0)
      begin
        ctrl_nxt.advanced_control_0 = byte_in;
        arg_nxt = lcd_cmd_pkg::ARG_NONE;
      end
      else if (arg_r == lcd_cmd_pkg::ARG_SKIP)
      begin
        arg_nxt = lcd_cmd_pkg::ARG_NONE;
      end
      else
      begin
        casez (byte_in)
          8'b0000????: col_nxt = {col_r[7:4], byte_in[3:0]};
          8'b0001????: col_nxt = {byte_in[3:0], col_r[3:0]};
          8'b00101???: ctrl_nxt.power_control[2:0] = byte_in[2:0];
          8'b00100???: ctrl_nxt.power_control[5:3] = byte_in[2:0];
          8'b01??????: ctrl_nxt.scroll_line = byte_in[5:0];
          8'b1011????: page_nxt = byte_in[3:0];
          8'b10000001: arg_nxt = lcd_cmd_pkg::ARG_CONTRAST;
          8'b1010000?: ctrl_nxt.panel_mirror_control[0] = byte_in[0];
          8'b1010001?: ctrl_nxt.bias_ratio_select = byte_in[0];
          8'b1010010?: ctrl_nxt.display_control_flags[1] = byte_in[0];
          8'b1010011?: ctrl_nxt.display_control_flags[0] = byte_in[0];
          8'b1010111?: ctrl_nxt.display_control_flags[2] = byte_in[0];
          8'b1100????: ctrl_nxt.panel_mirror_control[1] = byte_in[3];
          8'b11100010:
          begin
            ctrl_nxt = ctrl_default();
            col_nxt = `RST_COLUMN;
            page_nxt = `RST_PAGE;
            ret_nxt = 8'h00;
            hold_nxt = 1'b0;
            rcnt_nxt = `RESET_CYCLES;
          end
          8'b11100000:
          begin
            hold_nxt = 1'b1;
            ret_nxt = col_r;
          end
          8'b11101110:
          begin
            hold_nxt = 1'b0;
            col_nxt = ret_r;
          end
          8'b11111010: arg_nxt = lcd_cmd_pkg::ARG_ADV0;
          8'b11111000: arg_nxt = lcd_cmd_pkg::ARG_SKIP;
          8'b11111011: arg_nxt = lcd_cmd_pkg::ARG_SKIP;
          8'b1111111?: arg_nxt = lcd_cmd_pkg::ARG_SKIP;
          default: ;
        endcase
      end
    end
    else if (access && !is_data && is_read)
    begin
      // Status stays readable during reset so the host can poll busy.
      out_nxt = 8'h00;
      out_nxt[`ST_BUSY] = 1'b1;
      out_nxt[`ST_MIRROR] = ctrl_r.panel_mirror_control[0];
      out_nxt[`ST_DISP] = ctrl_r.display_control_flags[2];
      out_nxt[`ST_RESET] = 1'b1;
      oe_nxt = 1'b1;
    end
  end

  // Hardware reset loads defaults and starts the busy window.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r <= ctrl_default();
      arg_r <= lcd_cmd_pkg::ARG_NONE;
      col_r <= `RST_COLUMN;
      page_r <= `RST_PAGE;
      ret_r <= 8'h00;
      hold_r <= 1'b0;
      rcnt_r <= `RESET_CYCLES;
      out_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      arg_r <= arg_nxt;
      col_r <= col_nxt;
      page_r <= page_nxt;
      ret_r <= ret_nxt;
      hold_r <= hold_nxt;
      rcnt_r <= rcnt_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Registered view of the control state for the analog and driver blocks.
  // Display enable dominates: drivers idle and sleep follow it directly.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scroll_line <= `RST_SCROLL;
      contrast_volume <= `RST_CONTRAST;
      power_control <= `RST_POWER;
      bias_ratio_select <= 1'b0;
      pixel_invert <= 1'b0;
      all_pixels_on <= 1'b0;
      display_on_flag <= 1'b0;
      sleep_mode <= 1'b1;
      drivers_enable <= 1'b0;
      seg_mirror <= 1'b0;
      com_mirror <= 1'b0;
      bias_temp_slope <= 1'b1;
      cursor_hold_mode <= 1'b0;
      busy_flag <= 1'b1;
      reset_in_progress <= 1'b1;
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
    end
    else
    begin
      scroll_line <= ctrl_r.scroll_line;
      contrast_volume <= ctrl_r.contrast_volume;
      power_control <= ctrl_r.power_control;
      bias_ratio_select <= ctrl_r.bias_ratio_select;
      pixel_invert <= ctrl_r.display_control_flags[0];
      all_pixels_on <= ctrl_r.display_control_flags[1];
      display_on_flag <= ctrl_r.display_control_flags[2];
      sleep_mode <= !ctrl_r.display_control_flags[2];
      // Drivers come on one cycle after wake so supplies lead them.
      drivers_enable <= ctrl_r.display_control_flags[2] && !sleep_mode;
      seg_mirror <= ctrl_r.panel_mirror_control[0];
      com_mirror <= ctrl_r.panel_mirror_control[1];
      bias_temp_slope <= ctrl_r.advanced_control_0[7];
      cursor_hold_mode <= hold_r;
      busy_flag <= (rcnt_r != 4'h0);
      reset_in_progress <= (rcnt_r != 4'h0);
      bus_out <= out_r;
      bus_oe <= oe_r;
    end
  end
endmodule

// ==== logic/lcd_cmd_params.svh ====
`ifndef LCD_CMD_PARAMS_SVH
`define LCD_CMD_PARAMS_SVH
// Reset values of the control registers.
`define RST_SCROLL 6'h00
`define RST_COLUMN 8'h00
`define RST_PAGE 4'h0
`define RST_CONTRAST 6'h20
`define RST_POWER 6'h20
`define RST_ADV0 8'h90
// Pointer limits.
`define COL_LAST 8'h83
`define PAGE_LAST 4'h8
// Field positions inside the advanced control byte.
`define ADV0_PAGE_WRAP 0
`define ADV0_COL_WRAP 1
// Cycles that a reset sequence holds the busy and reset flags.
`define RESET_CYCLES 4'h4
// Status byte bit positions.
`define ST_BUSY 7
`define ST_MIRROR 6
`define ST_DISP 5
`define ST_RESET 4
`endif

// ==== logic/lcd_cmd_pkg.sv ====
package lcd_cmd_pkg;
  typedef enum logic [1:0] {ARG_NONE, ARG_CONTRAST, ARG_ADV0, ARG_SKIP} arg_e;
  typedef struct packed {
    logic [5:0] scroll_line;
    logic [5:0] contrast_volume;
    logic [5:0] power_control;
    logic bias_ratio_select;
    logic [2:0] display_control_flags;
    logic [1:0] panel_mirror_control;
    logic [7:0] advanced_control_0;
  } ctrl_s;
endpackage

// ==== logic/mem_port_if.sv ====
`timescale 1ns/1ps
// Display memory access between the decoder and its storage.
interface mem_port_if;
  logic wr_en;
  logic [3:0] page;
  logic [7:0] column;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport master (output wr_en, output page, output column, output wr_data, input rd_data);
  modport slave (input wr_en, input page, input column, input wr_data, output rd_data);
endinterface

// ==== logic/display_memory.sv ====
`timescale 1ns/1ps
// Nine pages of 132 bytes held in flip-flops, reset never touches them.
module display_memory #(
  parameter int PAGES = 9,
  parameter int COLS = 132
) (
  input wire logic clk,
  mem_port_if.slave mp
);
  logic [7:0] mem_r [PAGES*COLS];
  logic [7:0] rd_r;
  int idx;

  // Index is computed once; out-of-range addresses write nothing and read zero.
  always_comb
  begin
    idx = int'(mp.page) * COLS + int'(mp.column);
  end

  always_ff @(posedge clk)
  begin
    if (mp.wr_en && mp.page < PAGES && mp.column < COLS)
    begin
      mem_r[idx] <= mp.wr_data;
    end
  end

  // Combinational read, so the decoder can register it in two output stages, out_r then bus_out.
  always_comb
  begin
    rd_r = 8'h00;
    if (mp.page < PAGES && mp.column < COLS)
    begin
      rd_r = mem_r[idx];
    end
  end
  assign mp.rd_data = rd_r;
endmodule

// ==== tb/lcd_decoder_assertions.sv ====
`timescale 1ns/1ps
// Watches the decoder pins; every relation is judged only outside reset.
module lcd_decoder_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe_pin,
  input wire logic read_write_select,
  input wire logic bus_oe,
  input wire logic [5:0] scroll_line,
  input wire logic [5:0] contrast_volume,
  input wire logic [5:0] power_control,
  input wire logic seg_mirror,
  input wire logic com_mirror,
  input wire logic display_on_flag,
  input wire logic sleep_mode,
  input wire logic drivers_enable,
  input wire logic busy_flag,
  input wire logic reset_in_progress
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  defaults_loaded_a:
    assert property ($fell(rst) |-> contrast_volume == 6'h20 && power_control == 6'h20
      && scroll_line == 6'h00 && busy_flag) else $error("Defaults missing after reset.");
  busy_covers_reset_a:
    assert property (reset_in_progress |-> busy_flag) else $error("Reset flag without busy.");
  busy_ends_a:
    assert property ($fell(rst) |-> busy_flag ##[1:12] !busy_flag)
      else $error("Busy window after reset has the wrong length.");
  // A register may only move after a strobe or while a reset sequence loads defaults.
  regs_need_strobe_a:
    assert property ($changed({scroll_line, contrast_volume, power_control, seg_mirror,
      com_mirror}) |-> $past(strobe_pin, 2) || $past(reset_in_progress))
      else $error("Register changed without a host access.");
  read_drives_a:
    assert property ($rose(bus_oe) |-> read_write_select) else $error("Bus driven on a write.");
  wake_order_a:
    assert property ($fell(sleep_mode) |=> drivers_enable) else $error("Drivers late after wake.");
  drivers_after_wake_a:
    assert property (drivers_enable |-> !$past(sleep_mode)) else $error("Drivers on while asleep.");
  sleep_when_off_a:
    assert property (!display_on_flag |-> sleep_mode && !drivers_enable)
      else $error("Display off but awake.");
endmodule

bind lcd_command_decoder_regs lcd_decoder_assertions chk_u (.clk, .rst, .strobe_pin,
  .read_write_select, .bus_oe, .scroll_line, .contrast_volume, .power_control, .seg_mirror,
  .com_mirror, .display_on_flag, .sleep_mode, .drivers_enable, .busy_flag, .reset_in_progress);

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
// Host processor: one byte per strobe, after waiting up to 200 cycles for busy to clear.
// Factory test and reserved control bytes are sent like any other byte the bench asks for.
module host_model (
  input wire logic clk,
  input wire logic busy_flag,
  input wire logic [7:0] bus_out,
  output logic strobe_pin,
  output logic command_data_select,
  output logic read_write_select,
  output logic [7:0] bus_in
);
  // Idle levels at time zero.
  initial
  begin
    strobe_pin = 1'b0;
    command_data_select = 1'b0;
    read_write_select = 1'b0;
    bus_in = 8'h00;
  end

  // Setup of three clocks, a seven clock strobe, then the byte lines are inverted
  // so that a stale value can never pass for a fresh one.
  task automatic access(input logic cd, input logic rw, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    command_data_select <= cd;
    read_write_select <= rw;
    bus_in <= d;
    repeat (3) @(posedge clk);
    strobe_pin <= 1'b1;
    repeat (6) @(posedge clk);
    #1 q = bus_out;
    @(posedge clk);
    strobe_pin <= 1'b0;
    repeat (3) @(posedge clk);
    bus_in <= ~d;
  endtask
endmodule

// ==== tb/lcd_command_decoder_regs_test.sv ====
`timescale 1ns/1ps
// Bench: command and data bytes through the host model, compared with the command table.
module lcd_command_decoder_regs_test;
  logic clk, rst, strobe_pin, command_data_select, read_write_select, bus_oe;
  logic bias_ratio_select, pixel_invert, all_pixels_on, display_on_flag, sleep_mode;
  logic drivers_enable, seg_mirror, com_mirror, bias_temp_slope, cursor_hold_mode;
  logic busy_flag, reset_in_progress;
  logic [7:0] bus_in, bus_out, rd;
  logic [5:0] scroll_line, contrast_volume, power_control;
  logic [25:0] snap, exp;
  int error_cnt, comparisons, cycles;
  localparam logic [25:0] def_regs = {6'h00, 6'h20, 6'h20, 8'h02};
  logic [7:0] set_b[5] = '{8'ha1, 8'hc8, 8'ha7, 8'ha5, 8'ha3};
  logic [7:0] clr_b[5] = '{8'ha0, 8'hc0, 8'ha6, 8'ha4, 8'ha2};
  int pos[5] = '{3, 2, 6, 5, 7};
  logic [7:0] nop_b[6] = '{8'he3, 8'hac, 8'had, 8'hf8, 8'h00, 8'hf0};

  lcd_command_decoder_regs dut_u (.clk, .rst, .strobe_pin, .command_data_select,
    .read_write_select, .bus_in, .bus_out, .bus_oe, .scroll_line, .contrast_volume,
    .power_control, .bias_ratio_select, .pixel_invert, .all_pixels_on, .display_on_flag,
    .sleep_mode, .drivers_enable, .seg_mirror, .com_mirror, .bias_temp_slope,
    .cursor_hold_mode, .busy_flag, .reset_in_progress);
  host_model host_u (.clk, .busy_flag, .bus_out, .strobe_pin, .command_data_select,
    .read_write_select, .bus_in);

  // Clock of 4 ns.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // The sequence needs about 1100 cycles; a hang is cut off well beyond that.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  function automatic logic [25:0] regs_now();
    return {scroll_line, contrast_volume, power_control, bias_ratio_select, pixel_invert,
      all_pixels_on, display_on_flag, seg_mirror, com_mirror, bias_temp_slope, cursor_hold_mode};
  endfunction

  task automatic chk(input logic [25:0] seen, input logic [25:0] want);
    comparisons++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic cd, input logic [7:0] d);
    host_u.access(cd, 1'b0, d, rd);
  endtask

  // Reads one byte and compares it.
  task automatic rdb(input logic cd, input logic [7:0] want);
    host_u.access(cd, 1'b1, 8'h00, rd);
    chk(rd, want);
  endtask

  task automatic col(input logic [7:0] c);
    wr(1'b0, {4'h0, c[3:0]});
    wr(1'b0, {4'h1, c[7:4]});
  endtask

  task automatic give_verdict();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence; each step leans on the register state left by the one before.
  initial
  begin
    rst = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // Look after the edge so the outputs launched on it have settled.
    #1;
    chk(regs_now(), def_regs);
    chk({busy_flag, reset_in_progress, sleep_mode}, 3'b111);
    rdb(1'b0, 8'h00);
    exp = def_regs;
    for (int j = 0; j < 2; j++)
      foreach (set_b[i])
      begin
        wr(1'b0, j == 0 ? set_b[i] : clr_b[i]);
        exp[pos[i]] = (j == 0);
        chk(regs_now(), exp);
      end
    wr(1'b0, 8'h2f);
    wr(1'b0, 8'h21);
    wr(1'b0, 8'h7f);
    wr(1'b0, 8'h81);
    wr(1'b0, 8'h15);
    chk({scroll_line, contrast_volume, power_control}, {6'h3f, 6'h15, 6'h0f});
    snap = regs_now();
    wr(1'b0, 8'hb2);
    col(8'h83);
    foreach (nop_b[i])
      wr(1'b0, nop_b[i]);
    chk(regs_now(), snap);
    wr(1'b1, 8'h5a);
    wr(1'b1, 8'h3c);
    col(8'h83);
    rdb(1'b1, 8'h3c);
    col(8'h10);
    wr(1'b1, 8'h77);
    wr(1'b1, 8'h78);
    col(8'h10);
    rdb(1'b1, 8'h77);
    rdb(1'b1, 8'h78);
    wr(1'b0, 8'hfa);
    wr(1'b0, 8'h13);
    chk(bias_temp_slope, 1'b0);
    col(8'h83);
    wr(1'b1, 8'h11);
    wr(1'b1, 8'h22);
    wr(1'b0, 8'hb3);
    col(8'h00);
    rdb(1'b1, 8'h22);
    col(8'h05);
    wr(1'b1, 8'hcc);
    wr(1'b1, 8'hdd);
    col(8'h05);
    wr(1'b0, 8'he0);
    chk(cursor_hold_mode, 1'b1);
    rdb(1'b1, 8'hcc);
    rdb(1'b1, 8'hcc);
    wr(1'b1, 8'haa);
    wr(1'b0, 8'hee);
    chk(cursor_hold_mode, 1'b0);
    rdb(1'b1, 8'haa);
    rdb(1'b1, 8'hdd);
    wr(1'b0, 8'haf);
    chk({display_on_flag, sleep_mode, drivers_enable}, 3'b101);
    wr(1'b0, 8'ha1);
    rdb(1'b0, 8'h60);
    chk(bus_oe, 1'b1);
    wr(1'b0, 8'hae);
    wr(1'b0, 8'ha5);
    chk({display_on_flag, sleep_mode, drivers_enable, all_pixels_on}, 4'b0101);
    chk(bus_oe, 1'b0);
    wr(1'b0, 8'he2);
    rdb(1'b0, 8'h00);
    chk(regs_now(), def_regs);
    wr(1'b0, 8'hb3);
    col(8'h00);
    rdb(1'b1, 8'h22);
    // A second hardware reset in mid-run must clear a register set just before it.
    wr(1'b0, 8'ha7);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(regs_now(), def_regs);
    chk({busy_flag, reset_in_progress, bus_oe}, 3'b110);
    give_verdict();
  end
endmodule
